// File: design/fcio_axis_word.sv
// Operation
// RULE1 - The unit always occupies a full 16-bit word each way with fixed slots for four axes.
// RULE2 - All bits are active high, axis k owns bits 4k to 4k+3, and command bit 4k+3 is unused.
// RULE3 - A backward command moves the axis to its back end, homing first when not homed.
// RULE4 - A forward command moves the axis to its front end, homing first when not homed.
// RULE5 - Dropping a drive command mid-move makes the axis decelerate and stop where it is.
// RULE6 - An alarm clear command cancels that axis's active alarm.
// RULE7 - Status bit 4k+3 is set while axis k is ready with its servo on.
// RULE8 - Status bit 4k+2 reads one while axis k has no alarm and zero once an alarm occurs.
// RULE9 - Status bits 4k and 4k+1 show the axis inside the back and front end detection ranges.
// RULE10 - In pressing operation the same end bits also show pressing complete.
// RULE11 - The host locates each unit's words from that unit's head address.
// RULE12 - Unused command bits are ignored and slots of absent axes do nothing and read zero.
module fcio_axis_word #(
  parameter int NUM_AXES = fcio_pkg::NUM_AXES
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [15:0] axis_command_word, // Command word from host
  output logic [15:0] axis_status_word, // Status word to host
  input wire logic [NUM_AXES-1:0] axisPresent, // Axis attached
  input wire logic [NUM_AXES-1:0] servoOn, // Axis servo on
  input wire logic [NUM_AXES-1:0] alarmEvent, // Axis raises an alarm
  input wire logic [NUM_AXES-1:0] homeDone, // Home return finished
  input wire logic [NUM_AXES-1:0] homeValid, // Axis holds a home reference
  input wire logic [NUM_AXES-1:0] back_end_detect, // Inside back end range
  input wire logic [NUM_AXES-1:0] front_end_detect, // Inside front end range
  input wire logic [NUM_AXES-1:0] back_push_done, // Pressing done at back
  input wire logic [NUM_AXES-1:0] front_push_done, // Pressing done at front
  input wire logic [NUM_AXES-1:0] motionStopped, // Axis at standstill
  output logic [NUM_AXES-1:0] homeStart, // Run home return
  output logic [NUM_AXES-1:0] moveBack, // Drive toward back end
  output logic [NUM_AXES-1:0] moveFront, // Drive toward front end
  output logic [NUM_AXES-1:0] decelStop, // Decelerate and hold
  output logic [NUM_AXES-1:0] alarm_clear_cmd // Clear pulse to axis
);

  genvar k;
  generate
    for (k = 0; k < NUM_AXES; k++) begin : g_axis
      fcio_pkg::fcio_state_t state;
      fcio_pkg::fcio_state_t next_state;
      logic alarmActive;
      logic homed;
      logic homeTarget;

      // Absent axis sees no command
      wire present = axisPresent[k]; // RULE12
      wire drive_backward_cmd = present &&
        axis_command_word[fcio_pkg::NIB_W*k + fcio_pkg::CMD_BACK]; // RULE2
      wire drive_forward_cmd = present &&
        axis_command_word[fcio_pkg::NIB_W*k + fcio_pkg::CMD_FRONT]; // RULE2
      wire clearReq = present &&
        axis_command_word[fcio_pkg::NIB_W*k + fcio_pkg::CMD_CLEAR]; // RULE6
      wire anyDrive = drive_backward_cmd || drive_forward_cmd;
      wire canRun = servoOn[k] && !alarmActive;
      wire atBack = back_end_detect[k] || back_push_done[k]; // RULE10
      wire atFront = front_end_detect[k] || front_push_done[k]; // RULE10
      wire noFault = present && !alarmActive; // RULE8
      // Held command at a reached end must not restart the move
      wire backStart = canRun && drive_backward_cmd && !(homed && atBack); // RULE3
      wire frontStart = canRun && drive_forward_cmd && !(homed && atFront); // RULE4

      always_comb begin
        next_state = state;
        case (state)
          fcio_pkg::FC_IDLE: begin
            if (backStart) begin
              next_state = homed ? fcio_pkg::FC_MOVE_BACK : fcio_pkg::FC_HOMING; // RULE3
            end else if (frontStart) begin
              next_state = homed ? fcio_pkg::FC_MOVE_FRONT : fcio_pkg::FC_HOMING; // RULE4
            end
          end
          fcio_pkg::FC_HOMING: begin
            if (!canRun || !anyDrive) begin
              next_state = fcio_pkg::FC_STOPPING; // RULE5
            end else if (homeDone[k]) begin
              next_state = homeTarget ? fcio_pkg::FC_MOVE_FRONT : fcio_pkg::FC_MOVE_BACK;
            end
          end
          fcio_pkg::FC_MOVE_BACK: begin
            if (!canRun || !drive_backward_cmd) begin
              next_state = fcio_pkg::FC_STOPPING; // RULE5
            end else if (atBack) begin
              next_state = fcio_pkg::FC_IDLE; // RULE3
            end
          end
          fcio_pkg::FC_MOVE_FRONT: begin
            if (!canRun || !drive_forward_cmd) begin
              next_state = fcio_pkg::FC_STOPPING; // RULE5
            end else if (atFront) begin
              next_state = fcio_pkg::FC_IDLE; // RULE4
            end
          end
          fcio_pkg::FC_STOPPING: begin
            if (motionStopped[k]) begin
              next_state = fcio_pkg::FC_IDLE;
            end
          end
          default: next_state = fcio_pkg::FC_IDLE;
        endcase
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          state <= fcio_pkg::FC_IDLE;
        end else begin
          state <= next_state;
        end
      end

      // Remember which end was asked for while homing
      always_ff @(posedge clock) begin
        if (rst) begin
          homeTarget <= 1'b0;
        end else if (state == fcio_pkg::FC_IDLE && next_state == fcio_pkg::FC_HOMING) begin
          homeTarget <= !drive_backward_cmd;
        end
      end

      // Home reference; lost when axis reports it invalid
      always_ff @(posedge clock) begin
        if (rst) begin
          homed <= 1'b0;
        end else if (state == fcio_pkg::FC_HOMING && homeDone[k]) begin
          homed <= 1'b1;
        end else begin
          homed <= homed && homeValid[k];
        end
      end

      // New alarm wins over a clear in the same cycle
      always_ff @(posedge clock) begin
        if (rst) begin
          alarmActive <= 1'b0;
        end else if (present && alarmEvent[k]) begin
          alarmActive <= 1'b1;
        end else if (clearReq) begin
          alarmActive <= 1'b0; // RULE6
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          homeStart[k] <= 1'b0;
          moveBack[k] <= 1'b0;
          moveFront[k] <= 1'b0;
          decelStop[k] <= 1'b0;
          alarm_clear_cmd[k] <= 1'b0;
        end else begin
          homeStart[k] <= next_state == fcio_pkg::FC_HOMING; // RULE3
          moveBack[k] <= next_state == fcio_pkg::FC_MOVE_BACK; // RULE3
          moveFront[k] <= next_state == fcio_pkg::FC_MOVE_FRONT; // RULE4
          decelStop[k] <= next_state == fcio_pkg::FC_STOPPING; // RULE5
          alarm_clear_cmd[k] <= clearReq && alarmActive; // RULE6
        end
      end

      // Fixed nibble slot, zero when absent
      always_ff @(posedge clock) begin
        if (rst) begin
          axis_status_word[fcio_pkg::NIB_W*k +: fcio_pkg::NIB_W] <=
            fcio_pkg::STATUS_RST[fcio_pkg::NIB_W*k +: fcio_pkg::NIB_W]; // RULE1
        end else begin
          axis_status_word[fcio_pkg::NIB_W*k + fcio_pkg::ST_READY] <=
            present && servoOn[k]; // RULE7
          axis_status_word[fcio_pkg::NIB_W*k + fcio_pkg::ST_NOFAULT] <= noFault; // RULE8
          axis_status_word[fcio_pkg::NIB_W*k + fcio_pkg::ST_FRONT] <=
            present && atFront; // RULE9
          axis_status_word[fcio_pkg::NIB_W*k + fcio_pkg::ST_BACK] <=
            present && atBack; // RULE9
        end
      end
    end
  endgenerate

endmodule

// File: design/fcio_pkg.sv
package fcio_pkg;
  localparam int NUM_AXES = 4;
  localparam int NIB_W = 4;
  localparam int WORD_W = 16;
  // Command nibble field positions
  localparam int CMD_BACK = 0;
  localparam int CMD_FRONT = 1;
  localparam int CMD_CLEAR = 2;
  // Status nibble field positions
  localparam int ST_BACK = 0;
  localparam int ST_FRONT = 1;
  localparam int ST_NOFAULT = 2;
  localparam int ST_READY = 3;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // Axis motion states
  typedef enum logic [2:0] {
    FC_IDLE,
    FC_HOMING,
    FC_MOVE_BACK,
    FC_MOVE_FRONT,
    FC_STOPPING
  } fcio_state_t;
endpackage

// File: test/fcio_axis_model.sv
module fcio_axis_model (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic hold, // Keep off ends
  input wire logic [3:0] homeStart, // Homing
  input wire logic [3:0] moveBack, // Back move
  input wire logic [3:0] moveFront, // Front move
  output logic [3:0] homeDone, // Homed
  output logic [3:0] back_end_detect, // Back end
  output logic [3:0] front_end_detect, // Front end
  output logic [3:0] motionStopped // Standstill
);
  // Ends reached one cycle into a move unless held off
  always_ff @(posedge clock) begin
    if (rst) begin
      homeDone <= 4'h0;
      back_end_detect <= 4'h0;
      front_end_detect <= 4'h0;
      motionStopped <= 4'hf;
    end else begin
      homeDone <= homeStart;
      back_end_detect <= (back_end_detect & ~moveFront & ~homeStart) | (moveBack & {4{~hold}});
      front_end_detect <= (front_end_detect & ~moveBack & ~homeStart) | (moveFront & {4{~hold}});
      motionStopped <= ~(homeStart | moveBack | moveFront);
    end
  end
endmodule

// File: test/fcio_properties.sv
module fcio_properties #(parameter int NUM_AXES = 4) (
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic [15:0] axis_command_word, // Command
  input wire logic [15:0] axis_status_word, // Status
  input wire logic [NUM_AXES-1:0] axisPresent, // Attached
  input wire logic [NUM_AXES-1:0] servoOn, // Servo
  input wire logic [NUM_AXES-1:0] alarmEvent, // Alarm
  input wire logic [NUM_AXES-1:0] back_end_detect, // Back end
  input wire logic [NUM_AXES-1:0] back_push_done, // Back push
  input wire logic [NUM_AXES-1:0] homeStart, // Homing
  input wire logic [NUM_AXES-1:0] moveBack, // Back move
  input wire logic [NUM_AXES-1:0] moveFront, // Front move
  input wire logic [NUM_AXES-1:0] decelStop // Stopping
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ready_a: assert property (!$past(rst) |->
    axis_status_word[3] == $past(servoOn[0] && axisPresent[0])) else $error("ready bit");
  back_end_a: assert property (!$past(rst) |-> axis_status_word[4] ==
    $past(axisPresent[1] && (back_end_detect[1] || back_push_done[1]))) else $error("end bit");
  absent_slot_a: assert property (!axisPresent[3] [*2] |->
    axis_status_word[15:12] == 4'h0 && !moveBack[3]) else $error("absent slot");
  one_move_a: assert property (
    $onehot0({homeStart[0], moveBack[0], moveFront[0], decelStop[0]})) else $error("motion");
  back_cause_a: assert property ($rose(moveBack[0]) |->
    $past(axis_command_word[0])) else $error("back cause");
  drop_stop_a: assert property (moveBack[0] && $fell(axis_command_word[0]) |=>
    decelStop[0] && !moveBack[0]) else $error("no stop");
  fault_a: assert property (alarmEvent[2] && axisPresent[2] |->
    ##[1:2] !axis_status_word[10]) else $error("fault bit");
  alarm_clear_a: assert property (
    (axis_command_word[10] && !alarmEvent[2] && axisPresent[2]) [*4] |->
    axis_status_word[10]) else $error("clear");
endmodule

bind fcio_axis_word fcio_properties #(.NUM_AXES(NUM_AXES)) chk (.clock, .rst,
  .axis_command_word, .axis_status_word, .axisPresent, .servoOn, .alarmEvent,
  .back_end_detect, .back_push_done, .homeStart, .moveBack, .moveFront, .decelStop);

// File: test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] servo, pres, bp, fp; logic [15:0] exp;} fcio_row_t;
  logic clock = 0, rst = 1, hold = 0;
  logic [15:0] cmd = 16'h0000;
  logic [3:0] pres = 4'h0, servo = 4'h0, alm = 4'h0, bp = 4'h0, fp = 4'h0;
  logic [15:0] status;
  logic [3:0] hs, mb, mf, ds, hd, be, fe, ms, acc;
  int n_errors = 0, n_checks = 0;
  fcio_row_t rows [3] = '{'{4'hf, 4'hf, 4'h0, 4'h0, 16'hcccc},
    '{4'h5, 4'hf, 4'h3, 4'hc, 16'h6e5d}, '{4'hf, 4'h6, 4'hf, 4'h0, 16'h0dd0}};
  fcio_axis_word uut (.clock, .rst, .axis_command_word(cmd), .axis_status_word(status),
    .axisPresent(pres), .servoOn(servo), .alarmEvent(alm), .homeDone(hd), .homeValid(4'hf),
    .back_end_detect(be), .front_end_detect(fe), .back_push_done(bp), .front_push_done(fp),
    .motionStopped(ms), .homeStart(hs), .moveBack(mb), .moveFront(mf), .decelStop(ds),
    .alarm_clear_cmd(acc));
  fcio_axis_model model (.clock, .rst, .hold, .homeStart(hs), .moveBack(mb), .moveFront(mf),
    .homeDone(hd), .back_end_detect(be), .front_end_detect(fe), .motionStopped(ms));
  initial forever #10 clock = ~clock;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (400) @(posedge clock);
    n_errors++;
    end_of_test;
  end
  initial begin
    tick(20);
    @(posedge clock) rst <= 0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) {servo, pres, bp, fp} <= {rows[i].servo, rows[i].pres, rows[i].bp, rows[i].fp};
      tick(2);
      chk(status, rows[i].exp);
    end
    @(posedge clock) {servo, pres, bp, fp, hold, cmd} <= {16'hff00, 1'b1, 16'h0009};
    tick(6);
    chk({12'h0, mb}, 16'h0001);
    @(posedge clock) cmd <= 16'h0000;
    tick(5);
    chk({4'h0, hs, mb, ds}, 16'h0000);
    @(posedge clock) {hold, cmd} <= {1'b0, 16'h0021};
    tick(8);
    chk(status, 16'hcced);
    chk({8'h0, mb, mf}, 16'h0000);
    @(posedge clock) {alm, cmd} <= {4'h4, 16'h0000};
    @(posedge clock) alm <= 4'h0;
    tick(3);
    chk(status, 16'hc8ed);
    @(posedge clock) cmd <= 16'h0400;
    tick(1);
    chk({12'h0, acc}, 16'h0004);
    tick(4);
    chk(status, 16'hcced);
    @(posedge clock) {pres, cmd} <= {4'h7, 16'h1000};
    tick(4);
    chk(status, 16'h0ced);
    chk({12'h0, hs | mb}, 16'h0000);
    @(posedge clock) rst <= 1;
    tick(2);
    chk(status, 16'h0000);
    end_of_test;
  end
endmodule
